// [rtl/encl_admit_regs.svh]
// Constants for the enclave system instruction admission block.
// Assumes inclusion by name from rtl/; definitions only.
`ifndef ENCL_ADMIT_REGS_SVH
`define ENCL_ADMIT_REGS_SVH
// Opcode bytes 0F 01 CF packed first byte high
`define OPC_ENCLAVE_SYS 24'h0f01cf
// Register byte addresses
`define REG_CTRL 8'h00
`define REG_BITMAP_LO 8'h04
`define REG_BITMAP_HI 8'h08
`define REG_STATUS 8'h0c
`define REG_DISPATCHED 8'h10
// Control register field positions
`define CTRL_LOCK_BIT 0
`define CTRL_ENABLE_BIT 1
`define CTRL_CAP_BIT 2
`define CTRL_EXITING_BIT 3
`define CTRL_RESET 32'h0000_0000
`define BITMAP_RESET 32'h0000_0000
// Exiting bitmap catch-all bit and last own-bit leaf
`define BITMAP_TOP 6'h3f
`define BITMAP_OWN_MAX 32'h0000_003e
// Leaf numbers (plain defaults)
`define LEAF_MAX 32'h0000_0013
`define LEAF_TRACK 32'h0000_000c
`define LEAF_PERM_RESTRICT 32'h0000_000e
`define LEAF_TYPE_CHANGE 32'h0000_000f
`define LEAF_TRACK_CHECK 32'h0000_0011
// Error codes
`define GP_ERROR_CODE 32'h0000_0000
`define PAGE_CONFLICT_CODE 32'h0000_0007
`endif

// [rtl/encl_admit_pkg.sv]
// Types for the enclave system instruction admission block.
// Assumes the core and leaf handlers share the block's clock.
package encl_admit_pkg;
  // Outcome of one admitted or refused instruction
  typedef enum logic [2:0] {
    OUT_DISPATCH = 3'b000,
    OUT_TX_ABORT = 3'b001,
    OUT_INVALID_OPCODE = 3'b010,
    OUT_HYP_EXIT = 3'b011,
    OUT_GEN_PROTECT = 3'b100,
    OUT_CONFLICT = 3'b101
  } outcome_t;
  // Concurrency class of a running leaf
  typedef enum logic [1:0] {
    CLS_OTHER = 2'b00,
    CLS_TYPE_CHANGE = 2'b01,
    CLS_PERM_RESTRICT = 2'b10,
    CLS_TRACKING = 2'b11
  } leaf_class_t;
  // Instruction issued by the core pipeline
  typedef struct packed {
    logic valid;
    logic [23:0] opcode;
    logic pfxLock;
    logic pfxOpSize;
    logic pfxRep;
    logic pfxVex;
    logic [63:0] leafSelect;
    logic [39:0] page;
  } issue_t;
  // Processor state sampled with the issue
  typedef struct packed {
    logic txActive;
    logic protectionEnable;
    logic pagingEnable;
    logic virtual8086;
    logic systemManagement;
    logic [1:0] privilegeLevel;
    logic guest;
    logic mode64;
    logic dsExpandDown;
  } cpu_state_t;
  // Answer to the core and handlers
  typedef struct packed {
    logic valid;
    outcome_t kind;
    logic [31:0] errCode;
    logic [31:0] leaf;
    logic [1:0] slot;
    logic trackingConflict;
    logic wide64;
  } result_t;
  // Leaf handler completion
  typedef struct packed {
    logic valid;
    logic [1:0] slot;
  } done_t;
  // Page held by an accept or modify leaf elsewhere
  typedef struct packed {
    logic valid;
    logic [39:0] page;
  } claim_t;
endpackage : encl_admit_pkg

// [rtl/enclave_sys_instr_admission.sv]
// Admission, fault priority and dispatch for the enclave system instruction.
// Assumes core, leaf handlers and register master all run on ref_clk.
//
// Overview of operation
// [RQ1] Recognise three-byte opcode, operands implicit
// [RQ2] Leaf from accumulator low 32 bits
// [RQ3] Active transaction aborts before all checks
// [RQ4] Invalid opcode: no protection, v86, system-management
// [RQ5] Invalid opcode unless privilege level zero
// [RQ6] Invalid opcode when capability bit clear
// [RQ7] Invalid opcode on lock/opsize/rep/vector prefixes
// [RQ8] Guest exit per leaf bitmap bit
// [RQ9] Hypervisor exit between opcode and protection checks
// [RQ10] Protection fault unless feature locked and enabled
// [RQ11] Protection fault on unsupported leaf number
// [RQ12] Protection fault when paging disabled, after leaf
// [RQ13] Protection fault on expand-down data outside 64-bit
// [RQ14] Operand width 32 or 64 by mode
// [RQ15] Segment, address-size, extension prefixes ignored
// [RQ16] All checks passed: dispatch selected leaf
// [RQ17] Type change exclusive on page, conflict code
// [RQ18] Tracking leaves exclusive, tracking conflict qualifier
// [RQ19] Permission restrict exclusive on page
// [RQ20] First failing check only; no early effects
`timescale 1ns/1ps
`include "encl_admit_regs.svh"

module enclave_sys_instr_admission (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire encl_admit_pkg::issue_t issue,
  input wire encl_admit_pkg::cpu_state_t cpu,
  input wire encl_admit_pkg::claim_t claim,
  input wire encl_admit_pkg::done_t done,
  output encl_admit_pkg::result_t result,
  output logic issueReady,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata
);
  import encl_admit_pkg::*;

  localparam int SLOTS = 4;

  // Reset release synchroniser
  logic rstMeta_r;
  logic rstN;
  // Software registers
  logic [31:0] ctrl_r;
  logic [63:0] bitmap_r;
  logic [31:0] dispatched_r;
  outcome_t lastKind_r;
  logic [31:0] lastLeaf_r;
  // Running leaf slots
  logic [SLOTS-1:0] busy_r;
  leaf_class_t cls_r [SLOTS];
  logic [39:0] page_r [SLOTS];
  // Output flops
  result_t result_r;
  result_t result_nxt;
  logic ready_r;
  logic [31:0] rdata_r;
  // Decode
  logic taken;
  logic [31:0] leaf;
  logic [5:0] bitIdx;
  leaf_class_t newCls;
  logic [SLOTS-1:0] pageHit;
  logic [SLOTS-1:0] trackHit;
  logic [1:0] freeSlot;
  logic [SLOTS-1:0] busy_nxt;
  logic allocate;

  // Asynchronous assert, two-flop release; only constants under reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  // Request is taken only with our opcode while a slot is free
  // [RQ1] opcode match
  assign taken = issue.valid && ready_r && (issue.opcode == `OPC_ENCLAVE_SYS);
  // [RQ2] upper accumulator half dropped
  assign leaf = issue.leafSelect[31:0];
  // [RQ8] leaves above 62 share the top bit
  assign bitIdx = (leaf > `BITMAP_OWN_MAX) ? `BITMAP_TOP : leaf[5:0];

  // Concurrency class of the incoming leaf
  always_comb begin
    newCls = CLS_OTHER;
    if (leaf == `LEAF_TYPE_CHANGE) begin
      newCls = CLS_TYPE_CHANGE;
    end else if (leaf == `LEAF_PERM_RESTRICT) begin
      newCls = CLS_PERM_RESTRICT;
    end else if (leaf == `LEAF_TRACK || leaf == `LEAF_TRACK_CHECK) begin
      newCls = CLS_TRACKING;
    end
  end

  // Per-slot conflict detection and slot state
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : gSlot
      // [RQ17] same page held by a type change or restrict
      assign pageHit[g] = busy_r[g] && (page_r[g] == issue.page) &&
                          (cls_r[g] == CLS_TYPE_CHANGE || cls_r[g] == CLS_PERM_RESTRICT);
      // [RQ18] another tracking leaf running
      assign trackHit[g] = busy_r[g] && (cls_r[g] == CLS_TRACKING);
      // Class and page latch when this slot is filled
      always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
          cls_r[g] <= CLS_OTHER;
          page_r[g] <= 40'h0;
        end else begin
          if (allocate && freeSlot == 2'(g)) begin
            cls_r[g] <= newCls;
            page_r[g] <= issue.page;
          end
        end
      end
    end
  endgenerate

  // Lowest free slot
  always_comb begin
    freeSlot = 2'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (!busy_r[i]) begin
        freeSlot = 2'(i);
      end
    end
  end

  // Next busy vector; a done on the slot being filled cannot occur
  always_comb begin
    busy_nxt = busy_r;
    if (done.valid) begin
      busy_nxt[done.slot] = 1'b0;
    end
    if (allocate) begin
      busy_nxt[freeSlot] = 1'b1;
    end
  end

  // Slot occupancy in one process; fill beats a done in the same cycle
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      busy_r <= 4'h0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // Checks in fixed priority; only the first failure is reported
  always_comb begin
    result_nxt = '0;
    result_nxt.kind = OUT_DISPATCH;
    result_nxt.leaf = leaf;
    result_nxt.slot = freeSlot;
    // [RQ14] width from mode only, code segment size ignored
    result_nxt.wide64 = cpu.mode64;
    allocate = 1'b0;
    result_nxt.valid = taken;
    // [RQ20] priority chain, leaf effect only at the end
    // [RQ3] transaction abort first
    if (cpu.txActive) begin
      result_nxt.kind = OUT_TX_ABORT;
    // [RQ4] protection off, v86 or system management
    // [RQ6] capability bit clear
    // [RQ7] illegal prefixes
    // [RQ15] override and extension prefixes not examined
    end else if (!cpu.protectionEnable || cpu.virtual8086 || cpu.systemManagement ||
                 !ctrl_r[`CTRL_CAP_BIT] || issue.pfxLock || issue.pfxOpSize ||
                 issue.pfxRep || issue.pfxVex) begin
      result_nxt.kind = OUT_INVALID_OPCODE;
    // [RQ5] privilege above zero
    end else if (cpu.privilegeLevel != 2'h0) begin
      result_nxt.kind = OUT_INVALID_OPCODE;
    // [RQ8] guest exit on bitmap
    // [RQ9] exit sits before protection faults
    end else if (cpu.guest && ctrl_r[`CTRL_EXITING_BIT] && bitmap_r[bitIdx]) begin
      result_nxt.kind = OUT_HYP_EXIT;
    // [RQ10] feature lock and enable
    end else if (!ctrl_r[`CTRL_LOCK_BIT] || !ctrl_r[`CTRL_ENABLE_BIT]) begin
      result_nxt.kind = OUT_GEN_PROTECT;
      result_nxt.errCode = `GP_ERROR_CODE;
    // [RQ11] unsupported leaf
    end else if (leaf > `LEAF_MAX) begin
      result_nxt.kind = OUT_GEN_PROTECT;
      result_nxt.errCode = `GP_ERROR_CODE;
    // [RQ12] paging off
    end else if (!cpu.pagingEnable) begin
      result_nxt.kind = OUT_GEN_PROTECT;
      result_nxt.errCode = `GP_ERROR_CODE;
    // [RQ13] expand-down data outside 64-bit
    end else if (!cpu.mode64 && cpu.dsExpandDown) begin
      result_nxt.kind = OUT_GEN_PROTECT;
      result_nxt.errCode = `GP_ERROR_CODE;
    // [RQ17] type change against running page users
    // [RQ19] restrict against accept, modify and restrict
    end else if ((newCls == CLS_TYPE_CHANGE || newCls == CLS_PERM_RESTRICT) &&
                 ((|pageHit) || (claim.valid && claim.page == issue.page))) begin
      result_nxt.kind = OUT_CONFLICT;
      result_nxt.errCode = `PAGE_CONFLICT_CODE;
    // [RQ18] tracking against tracking
    end else if (newCls == CLS_TRACKING && (|trackHit)) begin
      result_nxt.kind = OUT_CONFLICT;
      result_nxt.errCode = `PAGE_CONFLICT_CODE;
      result_nxt.trackingConflict = 1'b1;
    end else begin
      // [RQ16] hand control to the selected leaf
      allocate = taken;
    end
  end

  // Answer register: valid is a one-cycle pulse
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      result_r <= '0;
    end else begin
      result_r <= result_nxt;
    end
  end

  // Ready falls on the same edge that fills the last slot
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ~&busy_nxt;
    end
  end

  // Software writes to control and bitmap
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_r <= `CTRL_RESET;
      bitmap_r <= {`BITMAP_RESET, `BITMAP_RESET};
    end else if (regWr) begin
      case (regAddr)
        `REG_CTRL: ctrl_r <= {28'h0, regWdata[3:0]};
        `REG_BITMAP_LO: bitmap_r[31:0] <= regWdata;
        `REG_BITMAP_HI: bitmap_r[63:32] <= regWdata;
        default: ;
      endcase
    end
  end

  // Status of the last answer and a dispatch counter
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      lastKind_r <= OUT_DISPATCH;
      lastLeaf_r <= 32'h0;
      dispatched_r <= 32'h0;
    end else begin
      if (result_nxt.valid) begin
        lastKind_r <= result_nxt.kind;
        lastLeaf_r <= leaf;
      end
      if (allocate) begin
        dispatched_r <= dispatched_r + 32'h1;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      rdata_r <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        `REG_CTRL: rdata_r <= ctrl_r;
        `REG_BITMAP_LO: rdata_r <= bitmap_r[31:0];
        `REG_BITMAP_HI: rdata_r <= bitmap_r[63:32];
        `REG_STATUS: rdata_r <= {12'h0, busy_r, lastLeaf_r[7:0], 5'h0, lastKind_r};
        `REG_DISPATCHED: rdata_r <= dispatched_r;
        default: rdata_r <= 32'h0;
      endcase
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign result = result_r;
  assign issueReady = ready_r;
  assign regRdata = rdata_r;

  // Checks kept next to the logic they guard
  tx_abort_first_a: assert property ( // [RQ3]
    @(posedge ref_clk) disable iff (!rstN)
    taken && cpu.txActive |=> result.valid && result.kind == OUT_TX_ABORT)
    else $error("transaction abort not first");

  priv_level_ud_a: assert property ( // [RQ5]
    @(posedge ref_clk) disable iff (!rstN)
    taken && !cpu.txActive && cpu.privilegeLevel != 2'h0 |=> result.kind == OUT_INVALID_OPCODE)
    else $error("nonzero privilege not refused");

  prefix_ud_a: assert property ( // [RQ7]
    @(posedge ref_clk) disable iff (!rstN)
    taken && !cpu.txActive && (issue.pfxLock || issue.pfxRep) |=> result.kind == OUT_INVALID_OPCODE)
    else $error("illegal prefix not refused");

  exit_bit_a: assert property ( // [RQ8]
    @(posedge ref_clk) disable iff (!rstN)
    result.valid && result.kind == OUT_HYP_EXIT |->
      $past(bitmap_r[bitIdx]) && $past(cpu.guest) && $past(cpu.privilegeLevel) == 2'h0)
    else $error("exit without its bitmap bit");

  gp_code_zero_a: assert property ( // [RQ10]
    @(posedge ref_clk) disable iff (!rstN)
    result.valid && result.kind == OUT_GEN_PROTECT |-> result.errCode == `GP_ERROR_CODE)
    else $error("protection fault code not zero");

  bad_leaf_gp_a: assert property ( // [RQ11]
    @(posedge ref_clk) disable iff (!rstN)
    taken && leaf > `LEAF_MAX |=> result.kind != OUT_DISPATCH)
    else $error("unsupported leaf dispatched");

  dispatch_slot_a: assert property ( // [RQ16]
    @(posedge ref_clk) disable iff (!rstN)
    result.valid && result.kind == OUT_DISPATCH |-> busy_r[result.slot] && $past(dispatched_r) + 32'h1 == dispatched_r)
    else $error("dispatch without slot or count");

  track_conflict_a: assert property ( // [RQ18]
    @(posedge ref_clk) disable iff (!rstN)
    result.valid && result.trackingConflict |-> result.kind == OUT_CONFLICT &&
      result.errCode == `PAGE_CONFLICT_CODE)
    else $error("tracking conflict misreported");

  no_early_effect_a: assert property ( // [RQ20]
    @(posedge ref_clk) disable iff (!rstN)
    result.valid && result.kind != OUT_DISPATCH |-> $stable(dispatched_r))
    else $error("leaf effect on refused instruction");

  foreign_opcode_a: assert property ( // [RQ1]
    @(posedge ref_clk) disable iff (!rstN)
    issue.valid && issue.opcode != `OPC_ENCLAVE_SYS |=> !result.valid)
    else $error("foreign opcode answered");

  leaf_low_half_a: assert property ( // [RQ2]
    @(posedge ref_clk) disable iff (!rstN)
    result.valid |-> result.leaf == $past(issue.leafSelect[31:0]))
    else $error("leaf not from low accumulator half");

  state_ud_a: assert property ( // [RQ4]
    @(posedge ref_clk) disable iff (!rstN)
    taken && !cpu.txActive && (!cpu.protectionEnable || cpu.virtual8086 || cpu.systemManagement) |=>
      result.valid && result.kind == OUT_INVALID_OPCODE)
    else $error("bad processor state not refused");

  cap_bit_ud_a: assert property ( // [RQ6]
    @(posedge ref_clk) disable iff (!rstN)
    taken && !cpu.txActive && !ctrl_r[`CTRL_CAP_BIT] |=> result.kind == OUT_INVALID_OPCODE)
    else $error("missing capability not refused");

  paging_gp_a: assert property ( // [RQ12]
    @(posedge ref_clk) disable iff (!rstN)
    taken && !cpu.pagingEnable |=> result.kind != OUT_DISPATCH)
    else $error("dispatched with paging off");

  expand_down_gp_a: assert property ( // [RQ13]
    @(posedge ref_clk) disable iff (!rstN)
    taken && !cpu.mode64 && cpu.dsExpandDown |=> result.kind != OUT_DISPATCH)
    else $error("dispatched with expand-down data");

  width_by_mode_a: assert property ( // [RQ14]
    @(posedge ref_clk) disable iff (!rstN)
    result.valid |-> result.wide64 == $past(cpu.mode64))
    else $error("operand width not from mode");

  full_not_ready_a: assert property ( // [RQ16]
    @(posedge ref_clk) disable iff (!rstN)
    &busy_r |-> !issueReady)
    else $error("ready with every slot busy");

  type_change_excl_a: assert property ( // [RQ17]
    @(posedge ref_clk) disable iff (!rstN)
    taken && newCls == CLS_TYPE_CHANGE && (|pageHit) |=> result.kind != OUT_DISPATCH)
    else $error("type change dispatched on held page");

  restrict_excl_a: assert property ( // [RQ19]
    @(posedge ref_clk) disable iff (!rstN)
    taken && newCls == CLS_PERM_RESTRICT && claim.valid && claim.page == issue.page |=>
      result.kind != OUT_DISPATCH)
    else $error("restrict dispatched on claimed page");
endmodule : enclave_sys_instr_admission

// [tb/core_issue_model.sv]
// Behavioural core pipeline that presents enclave instructions to the block.
// Assumes the bench loads one request at a time while issueReady is high.
`timescale 1ns/1ps

module core_issue_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire encl_admit_pkg::issue_t want,
  input wire logic issueReady,
  output encl_admit_pkg::issue_t issue
);
  import encl_admit_pkg::*;

  // Hold a request until an edge sees issueReady, then release it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      issue <= '0;
    end else if (issue.valid && issueReady) begin
      // Released fields turn to junk so stale values cannot pass as a request
      issue <= {1'b0, ~issue[$bits(issue_t)-2:0]};
    end else if (!issue.valid && want.valid) begin
      // Load only when idle: a held request never changes under the block
      issue <= want;
    end
  end
endmodule : core_issue_model

// [tb/tb.sv]
// Self-checking bench for the enclave instruction admission block.
// Assumes rtl/ is on the include path; one clock, no random stimulus.
`timescale 1ns/1ps
`include "encl_admit_regs.svh"

module tb;
  import encl_admit_pkg::*;
  // Good state: protected, paging, 64-bit, ring zero, host
  localparam logic [9:0] GOOD = 10'h182;
  logic ref_clk, nrst, regWr, regRd, issueReady;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, nDisp;
  issue_t want, issue;
  cpu_state_t cpu;
  claim_t claim;
  done_t done;
  result_t result;
  int nErrors, totalChecks;
  logic [1:0] slotQ[$]; // Slots of leaves still running
  logic [9:0] udMask[5] = '{10'h100, 10'h040, 10'h020, 10'h018, 10'h008};

  enclave_sys_instr_admission DUT (.ref_clk(ref_clk), .nrst(nrst), .issue(issue), .cpu(cpu), .claim(claim),
    .done(done), .result(result), .issueReady(issueReady), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  core_issue_model core (.ref_clk(ref_clk), .nrst(nrst), .want(want), .issueReady(issueReady), .issue(issue));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic giveVerdict();
    if (nErrors == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : giveVerdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rd

  // One instruction: m flips bits of the good state, pf is lock/opsize/rep/vex
  task automatic run(input logic [9:0] m, input logic [31:0] lf, input logic [3:0] pf, input outcome_t k,
                     input logic [39:0] pg = 40'h0, input logic keep = 1'b0);
    int i;
    @(posedge ref_clk);
    cpu <= cpu_state_t'(GOOD ^ m);
    want <= {1'b1, `OPC_ENCLAVE_SYS, pf, 32'hdead_beef, lf, pg};
    @(posedge ref_clk);
    want.valid <= 1'b0;
    #1;
    for (i = 0; i < 20 && result.valid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(result.valid, 1'b1);
    chk(32'(result.kind), 32'(k));
    if (k == OUT_GEN_PROTECT) chk(result.errCode, `GP_ERROR_CODE);
    if (k == OUT_CONFLICT) begin
      chk(result.errCode, `PAGE_CONFLICT_CODE);
      chk(result.trackingConflict, lf == `LEAF_TRACK || lf == `LEAF_TRACK_CHECK);
    end
    if (k == OUT_DISPATCH) begin
      chk(result.leaf, lf);
      chk(result.wide64, !m[1]);
      // Slots free in order, so the lowest free one is the count still held
      chk(result.slot, slotQ.size());
      nDisp++;
      slotQ.push_back(result.slot);
    end
    @(posedge ref_clk);
    #1 chk(result.valid, 1'b0);
    if (k == OUT_DISPATCH && !keep) freeSlot();
  endtask : run

  task automatic freeSlot();
    @(posedge ref_clk);
    done <= {1'b1, slotQ.pop_front()};
    @(posedge ref_clk);
    done.valid <= 1'b0;
    #1 chk(issueReady, 1'b1);
  endtask : freeSlot

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    nErrors++;
    giveVerdict();
  end

  initial begin
    int i;
    nrst = 1'b0;
    {regWr, regRd, regAddr, regWdata, nDisp} = '0;
    {want, claim, done} = '0;
    cpu = cpu_state_t'(GOOD);
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    for (i = 0; i < 10 && issueReady !== 1'b1; i++) @(posedge ref_clk);
    rd(`REG_CTRL, 32'h0);
    rd(`REG_BITMAP_LO, 32'h0);
    rd(`REG_BITMAP_HI, 32'h0);
    rd(8'h20, 32'h0);
    wr(`REG_CTRL, 32'h7);
    rd(`REG_CTRL, 32'h7);
    run(10'h000, 32'h3, 4'h0, OUT_DISPATCH);
    run(10'h002, 32'h3, 4'h0, OUT_DISPATCH);
    run(10'h3ff, 32'h3, 4'hf, OUT_TX_ABORT);
    foreach (udMask[j]) run(udMask[j], 32'h3, 4'h0, OUT_INVALID_OPCODE);
    for (i = 0; i < 4; i++) run(10'h0, 32'h3, 4'(1 << i), OUT_INVALID_OPCODE);
    wr(`REG_CTRL, 32'h6);
    run(10'h000, 32'h3, 4'h0, OUT_GEN_PROTECT);
    run(10'h008, 32'h3, 4'h0, OUT_INVALID_OPCODE);
    wr(`REG_CTRL, 32'h5);
    run(10'h000, 32'h3, 4'h0, OUT_GEN_PROTECT);
    wr(`REG_CTRL, 32'h3);
    run(10'h000, 32'h3, 4'h0, OUT_INVALID_OPCODE);
    wr(`REG_CTRL, 32'hf);
    wr(`REG_BITMAP_LO, 32'h20);
    wr(`REG_BITMAP_HI, 32'h8000_0000);
    run(10'h004, 32'h5, 4'h0, OUT_HYP_EXIT);
    run(10'h004, 32'h6, 4'h0, OUT_DISPATCH);
    run(10'h004, 32'h50, 4'h0, OUT_HYP_EXIT);
    run(10'h004, 32'h3f, 4'h0, OUT_HYP_EXIT);
    run(10'h004, 32'h3e, 4'h0, OUT_GEN_PROTECT);
    run(10'h000, 32'h5, 4'h0, OUT_DISPATCH);
    run(10'h00c, 32'h5, 4'h0, OUT_INVALID_OPCODE);
    run(10'h084, 32'h5, 4'h0, OUT_HYP_EXIT);
    run(10'h000, `LEAF_MAX, 4'h0, OUT_DISPATCH);
    run(10'h000, `LEAF_MAX + 32'h1, 4'h0, OUT_GEN_PROTECT);
    run(10'h080, 32'h3, 4'h0, OUT_GEN_PROTECT);
    run(10'h003, 32'h3, 4'h0, OUT_GEN_PROTECT);
    run(10'h001, 32'h3, 4'h0, OUT_DISPATCH);
    // Running leaves: type change on page 1, tracking; page 77 claimed
    @(posedge ref_clk);
    claim <= {1'b1, 40'h77};
    run(10'h000, `LEAF_TYPE_CHANGE, 4'h0, OUT_DISPATCH, 40'h1, 1'b1);
    run(10'h000, `LEAF_TRACK, 4'h0, OUT_DISPATCH, 40'h2, 1'b1);
    run(10'h080, `LEAF_TYPE_CHANGE, 4'h0, OUT_GEN_PROTECT, 40'h1);
    run(10'h000, `LEAF_TYPE_CHANGE, 4'h0, OUT_CONFLICT, 40'h1);
    run(10'h000, `LEAF_PERM_RESTRICT, 4'h0, OUT_CONFLICT, 40'h1);
    run(10'h000, `LEAF_TYPE_CHANGE, 4'h0, OUT_CONFLICT, 40'h77);
    run(10'h000, `LEAF_TRACK_CHECK, 4'h0, OUT_CONFLICT, 40'h9);
    run(10'h000, `LEAF_TRACK, 4'h0, OUT_CONFLICT, 40'h9);
    run(10'h000, `LEAF_TYPE_CHANGE, 4'h0, OUT_DISPATCH, 40'h3, 1'b1);
    run(10'h000, 32'h4, 4'h0, OUT_DISPATCH, 40'h1, 1'b1);
    chk(issueReady, 1'b0);
    // Status: all four slots busy, last answer a dispatch of leaf 4
    rd(`REG_STATUS, 32'h000f_0400);
    while (slotQ.size() > 0) freeSlot();
    rd(`REG_DISPATCHED, nDisp);
    // Foreign opcode must draw no answer at all
    @(posedge ref_clk);
    want <= {1'b1, 24'h0f01d7, 4'h0, 64'h3, 40'h0};
    @(posedge ref_clk);
    want.valid <= 1'b0;
    repeat (6) begin
      @(posedge ref_clk);
      #1 chk(result.valid, 1'b0);
    end
    giveVerdict();
  end
endmodule : tb
